// [hw/rms_pkg.sv]
package rms_pkg;

    // Width of the host data path and of the status word
    localparam int unsigned WORD_W = 16;

    // Field positions of the receiver and modem status word
    localparam int unsigned BIT_MODEM_CHANGE   = 15;
    localparam int unsigned BIT_RING           = 14;
    localparam int unsigned BIT_CTS            = 13;
    localparam int unsigned BIT_CARRIER        = 12;
    localparam int unsigned BIT_RX_ACTIVE      = 11;
    localparam int unsigned BIT_REVERSE_IN     = 10;
    localparam int unsigned BIT_RX_COMPLETE    = 7;
    localparam int unsigned BIT_RX_IRQ_EN      = 6;
    localparam int unsigned BIT_MODEM_IRQ_EN   = 5;
    localparam int unsigned BIT_REVERSE_OUT    = 3;
    localparam int unsigned BIT_RTS            = 2;
    localparam int unsigned BIT_DTR            = 1;

    // Number of modem leads watched, and their order in the lead vector
    localparam int unsigned LEAD_N       = 4;
    localparam int unsigned LEAD_RING    = 0;
    localparam int unsigned LEAD_CTS     = 1;
    localparam int unsigned LEAD_CARRIER = 2;
    localparam int unsigned LEAD_REVERSE = 3;

    // Default synchroniser depth for the modem leads
    localparam int unsigned SYNC_DEPTH = 2;

    // Reset values of the stored bits
    localparam logic RESET_FLAG = 1'b0;
    localparam logic RESET_DTR  = 1'b0;
    localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;

endpackage : rms_pkg

// [hw/rms_sync.sv]
// Multi-stage synchroniser for a group of asynchronous level inputs
module rms_sync #(
    parameter int unsigned WIDTH  = 4,
    parameter int unsigned STAGES = 2
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] stage;
    } rms_sync_state_t;

    rms_sync_state_t state_reg;
    rms_sync_state_t state_next;

    // Refuse depths that would not settle metastability
    initial begin
        if (STAGES < 2) begin
            $error("rms_sync needs at least two stages");
        end
        if (WIDTH < 1) begin
            $error("rms_sync needs a width of at least one");
        end
    end

    // Shift chain; only the next stage reads the first flop
    always_comb begin
        state_next = state_reg;
        state_next.stage[0] = async_i;
        for (int i = 1; i < STAGES; i++) begin
            state_next.stage[i] = state_reg.stage[i-1];
        end
    end

    // Register the chain
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Last stage is safe to use
    assign sync_o = state_reg.stage[STAGES-1];

endmodule // rms_sync

// [hw/rms_status_word.sv]
// Notes on behaviour
// RULE1: Carrier, clear-to-send or reverse-channel input edges of either polarity set bit 15.
// RULE2: Ring going inactive to active sets bit 15; ring falling does not.
// RULE3: Bit 15 clears on bus initialize and on every read of this word. A lead change in the same cycle as the read leaves it set.
// RULE4: Bit 14 shows the ring lead; ring is a pulsed lead, 2 s on, 4 s off.
// RULE5: Bit 13 follows clear-to-send: 1 on, 0 off.
// RULE6: Bit 12 reads 1 while carrier is received, 0 otherwise.
// RULE7: Bit 11 sets at the sampled center of a start bit.
// RULE8: Bit 11 clears on the rising edge of bit 7 and on initialize; read-only.
// RULE9: Bit 10 shows the reverse-channel input; a space reads as 1.
// RULE10: Bit 7 sets once a whole character has been assembled.
// RULE11: Receiver interrupt requested while bit 7 and bit 6 are both set.
// RULE12: Bit 7 clears when the receive buffer word is addressed, and on initialize.
// RULE13: Bit 6 is read/write and clears on initialize.
// RULE14: Bit 5 is read/write, clears on initialize, gates bit 15 onto an interrupt.
// RULE15: Bit 3 drives the reverse-channel output, space while set; clears on initialize.
// RULE16: Bit 2 drives request-to-send, or force-busy by option; clears on initialize.
// RULE17: Bit 1 drives terminal ready; initialize leaves it alone.
// RULE18: Software must clear terminal ready itself to disconnect.
// RULE19: Every initialize action is triggered by the host bus initialize signal.
// RULE20: Bits 9, 8 and 4 ignore writes and read as zero.
module rms_status_word
    import rms_pkg::*;
#(
    parameter int unsigned DATA_W         = rms_pkg::WORD_W,
    parameter int unsigned SYNC_STAGES    = rms_pkg::SYNC_DEPTH,
    parameter bit          RTS_FORCE_BUSY = 1'b0
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              reset_n_i,
    // Host bus initialize, level, same clock domain
    input  wire logic              host_bus_initialize_i,
    // Host register access
    input  wire logic              status_sel_i,
    input  wire logic              buffer_sel_i,
    input  wire logic              rd_i,
    input  wire logic              wr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o,
    // Receiver core events, same clock domain
    input  wire logic              start_center_i,
    input  wire logic              char_done_i,
    // Modem input leads, asynchronous
    input  wire logic              ring_i,
    input  wire logic              cts_status_i,
    input  wire logic              carrier_present_i,
    input  wire logic              reverse_channel_in_i,
    // Modem output leads
    output logic                   rts_output_o,
    output logic                   force_busy_o,
    output logic                   dtr_o,
    output logic                   reverse_channel_out_o,
    // Interrupt requests
    output logic                   receive_irq_o,
    output logic                   modem_irq_o
);

    import rms_pkg::*;

    // All state of the block
    typedef struct packed {
        logic [LEAD_N-1:0] lead_prev;
        logic              modem_change;
        logic              receiver_active;
        logic              receive_complete;
        logic              receive_irq_enable;
        logic              modem_irq_enable;
        logic              reverse_channel_out;
        logic              rts_bit;
        logic              dtr_bit;
        logic              primed;
        logic [DATA_W-1:0] rdata;
    } rms_state_t;

    rms_state_t state_reg;
    rms_state_t state_next;

    // Raw and synchronised modem leads
    logic [LEAD_N-1:0] lead_raw;
    logic [LEAD_N-1:0] lead_sync;

    // Decoded host actions
    logic status_read;
    logic status_write;
    logic buffer_touch;

    // Lead events and the receive-complete edge
    logic [LEAD_N-1:0] lead_rise;
    logic [LEAD_N-1:0] lead_fall;
    logic              change_event;
    logic              complete_rise;

    // Assembled word as software sees it
    logic [DATA_W-1:0] status_word;

    // The word layout is fixed at sixteen bits
    initial begin
        if (DATA_W != WORD_W) begin
            $error("rms_status_word supports only a sixteen bit data path");
        end
        if (SYNC_STAGES < 2) begin
            $error("rms_status_word needs at least two synchroniser stages");
        end
    end

    // Gather the modem leads in a fixed order
    always_comb begin
        lead_raw = '0;
        lead_raw[LEAD_RING]    = ring_i;
        lead_raw[LEAD_CTS]     = cts_status_i;
        lead_raw[LEAD_CARRIER] = carrier_present_i;
        lead_raw[LEAD_REVERSE] = reverse_channel_in_i;
    end

    // Leads come straight from line receivers, so they are retimed first
    rms_sync #(
        .WIDTH  (LEAD_N),
        .STAGES (SYNC_STAGES)
    ) u_lead_sync (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .async_i   (lead_raw),
        .sync_o    (lead_sync)
    );

    // Host actions on this word and on the receive buffer word
    assign status_read  = status_sel_i && rd_i;
    assign status_write = status_sel_i && wr_i;
    assign buffer_touch = buffer_sel_i && (rd_i || wr_i);

    // Edge detection on retimed leads; suppressed until the history is valid
    always_comb begin
        lead_rise = '0;
        lead_fall = '0;
        for (int i = 0; i < LEAD_N; i++) begin
            lead_rise[i] = state_reg.primed && lead_sync[i] && !state_reg.lead_prev[i];
            lead_fall[i] = state_reg.primed && !lead_sync[i] && state_reg.lead_prev[i];
        end
    end

    // Ring counts only on its rising edge, the other leads on both edges
    assign change_event = lead_rise[LEAD_RING]                             // [RULE2]
                        || lead_rise[LEAD_CTS] || lead_fall[LEAD_CTS]         // [RULE1]
                        || lead_rise[LEAD_CARRIER] || lead_fall[LEAD_CARRIER] // [RULE1]
                        || lead_rise[LEAD_REVERSE] || lead_fall[LEAD_REVERSE];// [RULE1]

    // Leading edge of the receive-complete flag
    assign complete_rise = state_next.receive_complete && !state_reg.receive_complete;

    // Word as read by software; unused positions stay zero
    always_comb begin
        status_word = RESET_WORD;                                           // [RULE20]
        status_word[BIT_MODEM_CHANGE] = state_reg.modem_change;
        status_word[BIT_RING]         = lead_sync[LEAD_RING];               // [RULE4]
        status_word[BIT_CTS]          = lead_sync[LEAD_CTS];                // [RULE5]
        status_word[BIT_CARRIER]      = lead_sync[LEAD_CARRIER];            // [RULE6]
        status_word[BIT_RX_ACTIVE]    = state_reg.receiver_active;
        status_word[BIT_REVERSE_IN]   = lead_sync[LEAD_REVERSE];            // [RULE9]
        status_word[BIT_RX_COMPLETE]  = state_reg.receive_complete;
        status_word[BIT_RX_IRQ_EN]    = state_reg.receive_irq_enable;
        status_word[BIT_MODEM_IRQ_EN] = state_reg.modem_irq_enable;
        status_word[BIT_REVERSE_OUT]  = state_reg.reverse_channel_out;
        status_word[BIT_RTS]          = state_reg.rts_bit;
        status_word[BIT_DTR]          = state_reg.dtr_bit;
    end

    // Next-state logic
    always_comb begin
        state_next = state_reg;

        // Lead history; the first cycle only fills it
        state_next.lead_prev = lead_sync;
        state_next.primed    = 1'b1;

        // Read data captured before the read side effect takes hold
        if (status_read) begin
            state_next.rdata = status_word;
        end

        // Software writable bits; reserved and read-only positions are ignored
        if (status_write) begin
            state_next.receive_irq_enable  = wdata_i[BIT_RX_IRQ_EN];       // [RULE13]
            state_next.modem_irq_enable    = wdata_i[BIT_MODEM_IRQ_EN];    // [RULE14]
            state_next.reverse_channel_out = wdata_i[BIT_REVERSE_OUT];     // [RULE15]
            state_next.rts_bit             = wdata_i[BIT_RTS];             // [RULE16]
            state_next.dtr_bit             = wdata_i[BIT_DTR];             // [RULE17]
        end

        // Modem change: read clears, a change in the same cycle wins
        if (status_read) begin
            state_next.modem_change = 1'b0;                                 // [RULE3]
        end
        if (change_event) begin
            state_next.modem_change = 1'b1;                                 // [RULE1] [RULE2]
        end

        // Receive complete: buffer access clears, a new character wins
        if (buffer_touch) begin
            state_next.receive_complete = 1'b0;                             // [RULE12]
        end
        if (char_done_i) begin
            state_next.receive_complete = 1'b1;                             // [RULE10]
        end

        // Initialize clears the flags, enables and output bits, but not terminal ready, which software owns
        if (host_bus_initialize_i) begin                                    // [RULE19]
            state_next.modem_change        = RESET_FLAG;                   // [RULE3]
            state_next.receive_complete    = RESET_FLAG;                   // [RULE12]
            state_next.receive_irq_enable  = RESET_FLAG;                   // [RULE13]
            state_next.modem_irq_enable    = RESET_FLAG;                   // [RULE14]
            state_next.reverse_channel_out = RESET_FLAG;                   // [RULE15]
            state_next.rts_bit             = RESET_FLAG;                   // [RULE16]
        end
    end

    // Receiver active depends on the final receive-complete value, so it sits apart
    logic rx_active_next;
    always_comb begin
        rx_active_next = state_reg.receiver_active;
        if (complete_rise || host_bus_initialize_i) begin
            rx_active_next = 1'b0;                                          // [RULE8] [RULE19]
        end
        if (start_center_i && !host_bus_initialize_i) begin
            rx_active_next = 1'b1;                                          // [RULE7]
        end
    end

    // State register; terminal ready has a power-up value only from reset
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg                     <= '0;
            state_reg.dtr_bit             <= RESET_DTR;                     // [RULE17]
            state_reg.rdata               <= RESET_WORD;
        end else begin
            state_reg                     <= state_next;
            state_reg.receiver_active     <= rx_active_next;
        end
    end

    // Read data from flops
    assign rdata_o = state_reg.rdata;

    // Request-to-send leaves on one of two leads, chosen by option
    assign rts_output_o = RTS_FORCE_BUSY ? 1'b0 : state_reg.rts_bit;       // [RULE16]
    assign force_busy_o = RTS_FORCE_BUSY ? state_reg.rts_bit : 1'b0;       // [RULE16]

    // Terminal ready and reverse channel are straight from their bits
    assign dtr_o                 = state_reg.dtr_bit;                       // [RULE17]
    assign reverse_channel_out_o = state_reg.reverse_channel_out;           // [RULE15]

    // Interrupt requests are levels; the enable only gates, never stores
    assign receive_irq_o = state_reg.receive_complete && state_reg.receive_irq_enable; // [RULE11]
    assign modem_irq_o   = state_reg.modem_change && state_reg.modem_irq_enable;       // [RULE14]

endmodule // rms_status_word

// [test/rms_status_word_asserts.sv]
module rms_sva (
    // Clock, reset and host side
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic        host_bus_initialize_i,
    input wire logic        status_sel_i,
    input wire logic        buffer_sel_i,
    input wire logic        rd_i,
    input wire logic        wr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    input wire logic        char_done_i,
    // Modem leads and outputs
    input wire logic        ring_i,
    input wire logic        cts_status_i,
    input wire logic        carrier_present_i,
    input wire logic        reverse_channel_in_i,
    input wire logic        rts_output_o,
    input wire logic        dtr_o,
    input wire logic        reverse_channel_out_o,
    input wire logic        receive_irq_o,
    input wire logic        modem_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] lead_q;
    logic [2:0] age_reg;
    logic       up_reg;
    logic       clean_reg;
    wire [3:0]  leads  = {ring_i, cts_status_i, carrier_present_i, reverse_channel_in_i};
    wire        rd_hit = status_sel_i && rd_i && !host_bus_initialize_i;
    // Ring falling is not an event, so only its rise counts here
    wire        ev     = up_reg && (lead_q[2:0] != leads[2:0] || (leads[3] && !lead_q[3]));

    // Age of the last lead event, and whether no read or init has followed it
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {lead_q, age_reg, up_reg, clean_reg} <= 9'h000;
        end else begin
            lead_q <= leads;
            up_reg <= 1'b1;
            age_reg <= ev ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
            clean_reg <= ev || (clean_reg && !rd_hit && !host_bus_initialize_i);
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // Leads settled through the synchroniser before the read is taken
    sequence s_quiet_rd;
        $stable(leads) [*4] ##0 rd_hit;
    endsequence

    a_change_flag: assert property (rd_hit && clean_reg && age_reg >= 3'h4 |=> rdata_o[15])
        else $error("lead change missing from change flag");
    a_read_clear: assert property (rd_hit && age_reg >= 3'h4 |=> !modem_irq_o)
        else $error("change flag survived a read");
    a_lead_mirror: assert property (s_quiet_rd |=> rdata_o[14:12] == $past(leads[3:1])
        && rdata_o[10] == $past(leads[0]))
        else $error("lead bits do not follow the modem");
    a_unused_zero: assert property (rd_hit |=> rdata_o[9:8] == 2'h0 && !rdata_o[4] && !rdata_o[0])
        else $error("unused bits read nonzero");
    a_init_clear: assert property (host_bus_initialize_i |=> !(receive_irq_o || modem_irq_o
        || rts_output_o || reverse_channel_out_o))
        else $error("initialize left a bit set");
    a_dtr_hold: assert property (host_bus_initialize_i && !(status_sel_i && wr_i) |=> $stable(dtr_o))
        else $error("initialize changed terminal ready");
    a_write_out: assert property (status_sel_i && wr_i && !host_bus_initialize_i
        |=> {reverse_channel_out_o, rts_output_o, dtr_o} == $past(wdata_i[3:1]))
        else $error("written control bits not on the leads");
    a_irq_mask: assert property (status_sel_i && wr_i && !host_bus_initialize_i
        |=> (!receive_irq_o || $past(wdata_i[6])) && (!modem_irq_o || $past(wdata_i[5])))
        else $error("interrupt raised while its enable is clear");
    a_buf_clear: assert property (buffer_sel_i && (rd_i || wr_i) && !char_done_i |=> !receive_irq_o)
        else $error("receive complete survived a buffer access");
endmodule // rms_sva

bind rms_status_word rms_sva i_rms_sva (.mclk_i, .reset_n_i, .host_bus_initialize_i, .status_sel_i,
    .buffer_sel_i, .rd_i, .wr_i, .wdata_i, .rdata_o, .char_done_i, .ring_i, .cts_status_i, .carrier_present_i,
    .reverse_channel_in_i, .rts_output_o, .dtr_o, .reverse_channel_out_o, .receive_irq_o, .modem_irq_o);

// [test/rms_modem.sv]
module rms_modem #(
    parameter int unsigned LAG = 8
) (
    // Clock and leads from the interface
    input  wire logic mclk_i,
    input  wire logic rts_i,
    input  wire logic dtr_i,
    input  wire logic rev_out_i,
    // Leads back to the interface
    output logic      ring_o,
    output logic      cts_o,
    output logic      carrier_o,
    output logic      rev_in_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [LAG-1:0] rts_q = '0, dtr_q = '0, rev_q = '0;

    initial {ring_o, cts_o, carrier_o, rev_in_o} = 4'h0;

    // Answers lag their control leads, so the interface sees truly late edges
    always @(posedge mclk_i) begin
        rts_q <= {rts_q[LAG-2:0], rts_i};
        dtr_q <= {dtr_q[LAG-2:0], dtr_i};
        rev_q <= {rev_q[LAG-2:0], rev_out_i};
        cts_o <= #1 rts_q[LAG-1];
        carrier_o <= #1 dtr_q[LAG-1];
        rev_in_o <= #1 rev_q[LAG-1];
    end

    // Caller sets the on and off times; ring is a pulsed lead, not a level
    task automatic ring_set(input logic on);
        @(posedge mclk_i);
        #1 ring_o = on;
    endtask
endmodule // rms_modem

// [test/tb_rms_status_word.sv]
module tb_rms_status_word;
    timeunit 1ns;
    timeprecision 100ps;
    import rms_pkg::*;
    // Bench signals carry the design port names
    logic mclk_i = 1'b0, reset_n_i = 1'b0, host_bus_initialize_i = 1'b0;
    logic status_sel_i = 1'b0, buffer_sel_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0;
    logic start_center_i = 1'b0, char_done_i = 1'b0;
    logic [WORD_W-1:0] wdata_i = 16'h0000, rdata_o;
    logic ring_i, cts_status_i, carrier_present_i, reverse_channel_in_i;
    logic rts_output_o, force_busy_o, dtr_o, reverse_channel_out_o, receive_irq_o, modem_irq_o;
    int bad_count = 0, compares = 0, cyc = 0;

    rms_status_word i_rms_status_word (.mclk_i, .reset_n_i, .host_bus_initialize_i, .status_sel_i, .buffer_sel_i,
        .rd_i, .wr_i, .wdata_i, .rdata_o, .start_center_i, .char_done_i, .ring_i, .cts_status_i, .carrier_present_i,
        .reverse_channel_in_i, .rts_output_o, .force_busy_o, .dtr_o, .reverse_channel_out_o, .receive_irq_o,
        .modem_irq_o);
    rms_modem i_rms_modem (.mclk_i, .rts_i(rts_output_o), .dtr_i(dtr_o), .rev_out_i(reverse_channel_out_o),
        .ring_o(ring_i), .cts_o(cts_status_i), .carrier_o(carrier_present_i), .rev_in_o(reverse_channel_in_i));

    always #5 mclk_i = ~mclk_i;
    // Run needs under two hundred cycles; the ceiling only catches a hang
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every driver step lands 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // Strobes end with an idle cycle so no signal is set twice in one step
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    // Select drops with its strobe, so a following access never sets it twice in one step
    task automatic rd_chk(input logic [WORD_W-1:0] exp);
        status_sel_i = 1'b1;
        rd_i = 1'b1;
        tick(1);
        status_sel_i = 1'b0;
        rd_i = 1'b0;
        tick(1);
        chk(rdata_o, exp);
    endtask
    task automatic wr(input logic [WORD_W-1:0] d);
        status_sel_i = 1'b1;
        wdata_i = d;
        wr_i = 1'b1;
        tick(1);
        status_sel_i = 1'b0;
        wr_i = 1'b0;
        tick(1);
    endtask
    task automatic touch();
        buffer_sel_i = 1'b1;
        rd_i = 1'b1;
        tick(1);
        buffer_sel_i = 1'b0;
        rd_i = 1'b0;
        tick(1);
    endtask

    task automatic t_write();
        rd_chk(16'h0000);
        wr(16'hFFFF);
        rd_chk(16'h006E);
        chk(16'({rts_output_o, dtr_o, reverse_channel_out_o, force_busy_o}), 16'h000E);
        tick(20);
        chk(16'(modem_irq_o), 16'h0001);
        rd_chk(16'hB46E);
        rd_chk(16'h346E);
    endtask
    task automatic t_ring();
        i_rms_modem.ring_set(1'b1);
        tick(20);
        rd_chk(16'hF46E);
        i_rms_modem.ring_set(1'b0);
        tick(40);
        rd_chk(16'h346E);
    endtask
    task automatic t_receive();
        pulse(start_center_i);
        rd_chk(16'h3C6E);
        pulse(char_done_i);
        chk(16'(receive_irq_o), 16'h0001);
        rd_chk(16'h34EE);
        touch();
        rd_chk(16'h346E);
        wr(16'h002E);
        pulse(char_done_i);
        chk(16'(receive_irq_o), 16'h0000);
        touch();
    endtask
    task automatic t_init();
        pulse(start_center_i);
        pulse(host_bus_initialize_i);
        rd_chk(16'h3402);
        wr(16'h0000);
        tick(20);
        rd_chk(16'h8000);
        rd_chk(16'h0000);
    endtask

    initial begin
        tick(8);
        reset_n_i = 1'b1;
        tick(2);
        t_write();
        t_ring();
        t_receive();
        t_init();
        test_done();
    end
endmodule // tb_rms_status_word
